// >>> rtl/descriptor_schedule_maps.v
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "sched_maps_consts.vh"

// Function
// - each category's done map sets a slot bit when that descriptor completes
// - reading a done map returns bits then clears those that were set
// - done maps are read-only and reset to zero
// - a skipped slot is neither processed nor read even if valid
// - a skipped descriptor's link does not change the visit order
// - skip masks are read/write and reset to all ones
// - the marked slot is the last one checked in a pass
// - after the marked slot the pass restarts at slot zero
// - final markers are 32-bit read/write one-hot fields resetting to zero
// - three independent sets of done, skip and marker registers
module descriptor_schedule_maps (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [11:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	input wire [95:0] valid_i,
	input wire [95:0] complete_i,
	output reg [31:0] dat_o,
	output wire ack_o,
	output wire err_o,
	output wire irq_o,
	output wire [95:0] visit_o,
	output wire [14:0] slot_o,
	output wire [2:0] wrap_o
);

	// ****************************************************
	// bus decode
	// ****************************************************
	reg ack;
	reg [95:0] skip;
	reg [95:0] last;
	reg [`IRQ_W-1:0] irq_stat;
	reg [`IRQ_W-1:0] irq_mask;
	reg [2:0] run;
	reg [11:0] hit_adr;
	reg [14:0] slot_q;
	wire req;
	wire [95:0] done;
	wire [95:0] done_gated;
	wire [2:0] visit;
	wire [2:0] wrap;
	wire [2:0] done_rd;
	wire [14:0] slot;
	wire known;
	wire wr;

	// register index: 0..12 for mapped words, 15 for unmapped
	function [3:0] decode;
		input [11:0] a;
		begin
			case (a)
				`ISO_DONE_OFF: decode = 4'h0;
				`ISO_SKIP_OFF: decode = 4'h1;
				`ISO_LAST_OFF: decode = 4'h2;
				`INT_DONE_OFF: decode = 4'h3;
				`INT_SKIP_OFF: decode = 4'h4;
				`INT_LAST_OFF: decode = 4'h5;
				`ASY_DONE_OFF: decode = 4'h6;
				`ASY_SKIP_OFF: decode = 4'h7;
				`ASY_LAST_OFF: decode = 4'h8;
				`IRQ_STAT_OFF: decode = 4'h9;
				`IRQ_MASK_OFF: decode = 4'ha;
				`SCAN_CTRL_OFF: decode = 4'hb;
				`SCAN_STAT_OFF: decode = 4'hc;
				default: decode = 4'hf;
			endcase
		end
	endfunction

	// byte-lane merge for writable words
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] s;
		begin
			merge = {s[3] ? nw[31:24] : old[31:24],
				s[2] ? nw[23:16] : old[23:16],
				s[1] ? nw[15:8] : old[15:8],
				s[0] ? nw[7:0] : old[7:0]};
		end
	endfunction

	assign req = cyc_i & stb_i & ~ack;
	assign known = decode(adr_i) != 4'hf;
	// single-cycle answer; ack drops the cycle after it was given
	assign ack_o = ack & known;
	assign err_o = ack & ~known;
	assign wr = ack & we_i & known;

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			hit_adr <= 12'h000;
		end else begin
			ack <= req;
			hit_adr <= adr_i;
		end
	end

	// ****************************************************
	// per-category maps and scanners
	// ****************************************************
	genvar c;
	generate
		for (c = 0; c < 3; c = c + 1) begin : cat
			localparam [3:0] DONE_IDX = c * 3;
			localparam [3:0] SKIP_IDX = c * 3 + 1;
			localparam [3:0] LAST_IDX = c * 3 + 2;
			// done map clears on the acknowledged read only
			assign done_rd[c] = ack & ~we_i &
				(decode(adr_i) == DONE_IDX);
			done_map u_done (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.set_i(complete_i[32*c+31:32*c]),
				.clear_i(done_rd[c]),
				.map_o(done[32*c+31:32*c])
			);
			slot_scanner u_scan (
				.clk_i(clk_i),
				.rst_i(rst_i),
				.run_i(run[c]),
				.skip_i(skip[32*c+31:32*c]),
				.last_i(last[32*c+31:32*c]),
				.valid_i(valid_i[32*c+31:32*c]),
				.done_i(done[32*c+31:32*c]),
				.slot_o(slot[5*c+4:5*c]),
				.visit_o(visit[c]),
				.wrap_o(wrap[c]),
				.done_o(done_gated[32*c+31:32*c])
			);
			assign visit_o[32*c+31:32*c] = visit[c] ?
				(32'h00000001 << slot_q[5*c+4:5*c]) : 32'h00000000;

			always @(posedge clk_i) begin
				if (rst_i) begin
					skip[32*c+31:32*c] <= `SKIP_RST;
					last[32*c+31:32*c] <= `LAST_RST;
				end else if (wr) begin
					if (decode(adr_i) == SKIP_IDX) begin
						skip[32*c+31:32*c] <= merge(
							skip[32*c+31:32*c], dat_i, sel_i);
					end
					if (decode(adr_i) == LAST_IDX) begin
						last[32*c+31:32*c] <= merge(
							last[32*c+31:32*c], dat_i, sel_i);
					end
				end
			end
		end
	endgenerate

	// slot that the visit pulse refers to
	always @(posedge clk_i) begin
		if (rst_i) begin
			slot_q <= 15'h0000;
		end else begin
			slot_q <= slot;
		end
	end
	assign slot_o = slot_q;
	assign wrap_o = wrap;

	// ****************************************************
	// scan control and interrupts
	// ****************************************************
	wire [`IRQ_W-1:0] irq_ev;
	wire [2:0] any_done;
	assign any_done = {|complete_i[95:64], |complete_i[63:32],
		|complete_i[31:0]};
	assign irq_ev = {wrap, any_done};

	always @(posedge clk_i) begin
		if (rst_i) begin
			run <= 3'h0;
			irq_mask <= {`IRQ_W{1'b0}};
			irq_stat <= {`IRQ_W{1'b0}};
		end else begin
			if (wr && decode(adr_i) == 4'hb && sel_i[0]) begin
				run <= dat_i[2:0];
			end
			if (wr && decode(adr_i) == 4'ha && sel_i[0]) begin
				irq_mask <= dat_i[`IRQ_W-1:0];
			end
			// set wins over write-one-to-clear
			if (wr && decode(adr_i) == 4'h9 && sel_i[0]) begin
				irq_stat <= (irq_stat & ~dat_i[`IRQ_W-1:0]) | irq_ev;
			end else begin
				irq_stat <= irq_stat | irq_ev;
			end
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	// ****************************************************
	// read data, registered on the request edge
	// ****************************************************
	reg [31:0] next_dat;
	// a completion on the request edge is reported, else the clear loses it
	always @* begin
		case (decode(adr_i))
			4'h0: next_dat = done[31:0] | complete_i[31:0];
			4'h1: next_dat = skip[31:0];
			4'h2: next_dat = last[31:0];
			4'h3: next_dat = done[63:32] | complete_i[63:32];
			4'h4: next_dat = skip[63:32];
			4'h5: next_dat = last[63:32];
			4'h6: next_dat = done[95:64] | complete_i[95:64];
			4'h7: next_dat = skip[95:64];
			4'h8: next_dat = last[95:64];
			4'h9: next_dat = {26'h0000000, irq_stat};
			4'ha: next_dat = {26'h0000000, irq_mask};
			4'hb: next_dat = {29'h00000000, run};
			4'hc: next_dat = {17'h00000, slot_q};
			default: next_dat = 32'h00000000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h00000000;
		end else if (req) begin
			dat_o <= next_dat;
		end
	end

endmodule

// >>> rtl/sched_maps_consts.vh
`ifndef SCHED_MAPS_CONSTS_VH
`define SCHED_MAPS_CONSTS_VH

// ****************************************************
// register byte offsets
// ****************************************************
`define ISO_DONE_OFF 12'h130
`define ISO_SKIP_OFF 12'h134
`define ISO_LAST_OFF 12'h138
`define INT_DONE_OFF 12'h140
`define INT_SKIP_OFF 12'h144
`define INT_LAST_OFF 12'h148
`define ASY_DONE_OFF 12'h150
`define ASY_SKIP_OFF 12'h154
`define ASY_LAST_OFF 12'h158
`define IRQ_STAT_OFF 12'h160
`define IRQ_MASK_OFF 12'h164
`define SCAN_CTRL_OFF 12'h168
`define SCAN_STAT_OFF 12'h16c

// ****************************************************
// reset values and widths
// ****************************************************
`define DONE_RST 32'h00000000
`define SKIP_RST 32'hffffffff
`define LAST_RST 32'h00000000
`define NSLOT 32
`define SLOT_W 5
`define CAT_ISO 2'h0
`define CAT_INT 2'h1
`define CAT_ASY 2'h2
// irq status bits: per category a completion and a pass wrap
`define IRQ_W 6

`endif

// >>> rtl/done_map.v
`timescale 1ns/1ps
`include "sched_maps_consts.vh"

module done_map (
	input wire clk_i,
	input wire rst_i,
	input wire [31:0] set_i,
	input wire clear_i,
	output reg [31:0] map_o
);

	// ****************************************************
	// sticky completion bits, cleared by read
	// ****************************************************
	always @(posedge clk_i) begin
		if (rst_i) begin
			map_o <= `DONE_RST;
		end else if (clear_i) begin
			// new set wins over the read clear
			map_o <= set_i;
		end else begin
			map_o <= map_o | set_i;
		end
	end

endmodule

// >>> rtl/slot_scanner.v
`timescale 1ns/1ps
`include "sched_maps_consts.vh"

module slot_scanner (
	input wire clk_i,
	input wire rst_i,
	input wire run_i,
	input wire [31:0] skip_i,
	input wire [31:0] last_i,
	input wire [31:0] valid_i,
	input wire [31:0] done_i,
	output reg [4:0] slot_o,
	output reg visit_o,
	output reg wrap_o,
	output reg [31:0] done_o
);

	// ****************************************************
	// one slot checked per clock
	// ****************************************************
	wire at_last;
	wire take;
	// with no marker set the whole table is scanned
	assign at_last = (last_i == 32'h00000000) ?
		(slot_o == 5'h1f) : last_i[slot_o];
	// skipped slots are never read; links play no part in order
	assign take = valid_i[slot_o] & ~skip_i[slot_o];

	always @(posedge clk_i) begin
		if (rst_i) begin
			slot_o <= 5'h00;
			visit_o <= 1'b0;
			wrap_o <= 1'b0;
			done_o <= 32'h00000000;
		end else begin
			visit_o <= run_i & take;
			wrap_o <= run_i & at_last;
			done_o <= done_i & ~skip_i;
			if (run_i) begin
				if (at_last) begin
					slot_o <= 5'h00;
				end else begin
					slot_o <= slot_o + 5'h01;
				end
			end
		end
	end

endmodule

// >>> dv/sched_maps_asserts.sv
`timescale 1ns/1ps
module sched_maps_asserts (
	input wire clk_i,
	input wire rst_i,
	input wire cyc_i,
	input wire stb_i,
	input wire [11:0] adr_i,
	input wire [31:0] dat_o,
	input wire ack_o,
	input wire err_o,
	input wire irq_o,
	input wire [95:0] valid_i,
	input wire [95:0] visit_o,
	input wire [14:0] slot_o,
	input wire [2:0] wrap_o
);
// ****************
// checks
// ****************
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
sequence s_take;
	cyc_i && stb_i && !ack_o && !err_o;
endsequence
property p_answer; s_take |=> ack_o ^ err_o; endproperty
a_answer: assert property (p_answer) else $error("no answer");
property p_pulse; ack_o || err_o |=> !ack_o && !err_o; endproperty
a_pulse: assert property (p_pulse) else $error("answer too long");
property p_idle; !stb_i |=> !ack_o && !err_o; endproperty
a_idle: assert property (p_idle) else $error("answer unasked");
property p_unmap; s_take ##0 adr_i[11:8] != 4'h1 |=> err_o; endproperty
a_unmap: assert property (p_unmap) else $error("unmapped not refused");
property p_hold; !(cyc_i && stb_i) |=> $stable(dat_o); endproperty
a_hold: assert property (p_hold) else $error("read data moved");
property p_visit; (visit_o & ~valid_i & ~$past(valid_i)) == 96'h0; endproperty
a_visit: assert property (p_visit) else $error("invalid slot visited");
property p_one;
	$onehot0(visit_o[95:64]) && $onehot0(visit_o[63:32])
	&& $onehot0(visit_o[31:0]);
endproperty
a_one: assert property (p_one) else $error("several visits");
property p_wrap; wrap_o[2] |-> ##[0:33] slot_o[14:10] == 5'h0; endproperty
a_wrap: assert property (p_wrap) else $error("no restart");
property p_rst;
	$fell(rst_i) |-> !irq_o && !ack_o && visit_o == 96'h0 && wrap_o == 3'h0;
endproperty
a_rst: assert property (p_rst) else $error("dirty reset");
endmodule
bind descriptor_schedule_maps sched_maps_asserts u_sched_maps_asserts (
	.clk_i, .rst_i, .cyc_i, .stb_i, .adr_i, .dat_o, .ack_o, .err_o, .irq_o,
	.valid_i, .visit_o, .slot_o, .wrap_o);

// >>> dv/testbench.sv
`timescale 1ns/1ps
`include "sched_maps_consts.vh"
module testbench;
// ****************
// bench
// ****************
logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, er;
logic [11:0] adr_i = 0;
logic [3:0] sel_i = 0;
logic [31:0] dat_i = 0, dat_o, q, acc;
logic [95:0] valid_i = 0, complete_i = 0, visit_o;
logic [14:0] slot_o;
logic [2:0] wrap_o;
logic ack_o, err_o, irq_o;
int n_mismatch = 0, n_checks = 0, w;
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
descriptor_schedule_maps u_descriptor_schedule_maps (.clk_i, .rst_i, .cyc_i,
	.stb_i, .we_i, .adr_i, .sel_i, .dat_i, .valid_i, .complete_i, .dat_o,
	.ack_o, .err_o, .irq_o, .visit_o, .slot_o, .wrap_o);
initial forever #12.5 clk_i = ~clk_i;
// c pulses completions in the answer cycle
task bus(input wr, input [11:0] a, input [31:0] d, input [95:0] c);
	int n;
	n = 0;
	cyc_i <= 1;
	stb_i <= 1;
	we_i <= wr;
	adr_i <= a;
	dat_i <= d;
	sel_i <= 4'hf;
	@(posedge clk_i);
	complete_i <= c;
	do begin
		@(posedge clk_i);
		complete_i <= 0;
		n++;
	end while (!ack_o && !err_o && n < 20);
	q = dat_o;
	er = err_o;
	cyc_i <= 0;
	stb_i <= 0;
	we_i <= 0;
	if (n >= 20) begin
		n_mismatch++;
		complete_run;
	end
	@(posedge clk_i);
endtask
task t_reset;
	for (int c = 0; c < 3; c++)
		for (int k = 0; k < 3; k++) begin
			bus(0, 12'(12'h130 + c * 16 + k * 4), 0, 0);
			`CHK(q, k == 1 ? 32'hffffffff : 32'h0)
		end
	$display("reset values done");
endtask
task t_rw;
	for (int c = 0; c < 3; c++) begin
		bus(1, 12'(12'h134 + c * 16), 32'h5a5a0000 + c, 0);
		bus(1, 12'(12'h138 + c * 16), 32'h1 << c, 0);
		bus(1, 12'(12'h130 + c * 16), 32'hffffffff, 0);
	end
	for (int c = 0; c < 3; c++) begin
		bus(0, 12'(12'h134 + c * 16), 0, 0);
		`CHK(q, 32'h5a5a0000 + c)
		bus(0, 12'(12'h138 + c * 16), 0, 0);
		`CHK(q, 32'h1 << c)
		bus(0, 12'(12'h130 + c * 16), 0, 0);
		`CHK(q, 32'h0)
	end
	bus(0, 12'h15c, 0, 0);
	`CHK(er, 1'b1)
	$display("read write done");
endtask
task t_done;
	bus(0, `INT_DONE_OFF, 0, (96'h1 << 40) | (96'h1 << 95));
	`CHK(q, 32'h0)
	bus(0, `INT_DONE_OFF, 0, 0);
	`CHK(q, 32'h100)
	bus(0, `INT_DONE_OFF, 0, 0);
	`CHK(q, 32'h0)
	bus(0, `ASY_DONE_OFF, 0, 0);
	`CHK(q, 32'h80000000)
	$display("done maps done");
endtask
// slot 1 valid but skipped, slot 3 beyond the final marker
task t_scan;
	acc = 0;
	w = 0;
	bus(1, `ASY_SKIP_OFF, ~32'hd, 0);
	bus(1, `ASY_LAST_OFF, 32'h4, 0);
	valid_i[95:64] <= 32'hf;
	bus(1, `SCAN_CTRL_OFF, 32'h4, 0);
	repeat (100) begin
		@(posedge clk_i);
		acc = acc | visit_o[95:64];
		w = w + wrap_o[2];
	end
	`CHK(acc, 32'h5)
	`CHK(w > 1, 1'b1)
	$display("scan done");
endtask
task t_irq;
	bus(1, `SCAN_CTRL_OFF, 0, 0);
	bus(1, `IRQ_MASK_OFF, 0, 0);
	`CHK(irq_o, 1'b0)
	bus(1, `IRQ_MASK_OFF, 32'h20, 0);
	`CHK(irq_o, 1'b1)
	bus(1, `IRQ_STAT_OFF, 32'h20, 0);
	`CHK(irq_o, 1'b0)
	$display("irq done");
endtask
task complete_run;
	$display("checks %0d mismatches %0d", n_checks, n_mismatch);
	if (n_mismatch == 0 && n_checks > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
initial begin
	repeat (8) @(posedge clk_i);
	rst_i <= 0;
	t_reset;
	t_rw;
	t_done;
	t_scan;
	t_irq;
	complete_run;
end
// tests need about 225 cycles
initial begin
	#100000;
	n_mismatch++;
	complete_run;
end
endmodule
